// *** core/ccs_comp_gate.sv ***
// hierarchical enable, status aggregation and control broadcast
`timescale 1ns/1ns
module ccs_comp_gate
  import ccs_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  ccs_link_if.gate  lk
);
  logic [CCS_COMPONENTS-1:0]          next_active;
  logic [CCS_COMPONENTS*CCS_AW_W-1:0] next_aw;
  logic                               next_status;
  logic [CCS_COMPONENTS-1:0]          active;
  logic [CCS_COMPONENTS*CCS_AW_W-1:0] aw;
  logic                               status;

  // common enable overrides each component enable
  genvar g;
  generate
    for (g = 0; g < CCS_COMPONENTS; g++) begin : g_comp
      assign next_active[g] = lk.common_enable & lk.comp_enable[g];
      assign next_aw[g*CCS_AW_W +: CCS_AW_W] = lk.common_aw_en;
    end
  endgenerate

  // device status is the aggregate of all components
  always_comb begin
    next_status = |lk.comp_status;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      active <= '0;
      aw     <= '0;
      status <= 1'b0;
    end else begin
      active <= next_active;
      aw     <= next_aw;
      status <= next_status;
    end
  end

  assign lk.comp_active   = active;
  assign lk.comp_aw_en    = aw;
  assign lk.common_status = status;

  common_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !lk.common_enable |=> lk.comp_active == '0)
    else $error("component active while common enable is clear");
  status_sum_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ##1 lk.common_status == |$past(lk.comp_status))
    else $error("common status is not the component aggregate");
endmodule : ccs_comp_gate

// *** core/ccs_id_replica.sv ***
// replicated device identifier holder, kept across function level reset
`timescale 1ns/1ns
module ccs_id_replica
  import ccs_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic flr_i,
  ccs_link_if.idrep lk
);
  logic [7:0] next_rep_id;
  logic [7:0] rep_id;

  // copy on each load; function level reset is deliberately not looked at
  always_comb begin
    next_rep_id = rep_id;
    if (lk.id_load) begin
      next_rep_id = lk.id_value;
    end
  end

  // only the conventional reset clears the copy
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rep_id <= CCS_RID_RESET;
    end else begin
      rep_id <= next_rep_id;
    end
  end

  assign lk.rep_id = rep_id;

  rid_reset_a: assert property (@(posedge clk_sys_i)
    rst_i |=> lk.rep_id == CCS_RID_RESET)
    else $error("identifier copy not cleared by reset");
  rid_flr_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    flr_i && !lk.id_load |=> $stable(lk.rep_id))
    else $error("identifier copy changed by function level reset");
  rid_copy_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    lk.id_load |=> lk.rep_id == $past(lk.id_value))
    else $error("identifier copy does not match the loaded value");
endmodule : ccs_id_replica

// *** core/ccs_link_if.sv ***
// internal carrier between the register hub and its two helpers
`timescale 1ns/1ns
interface ccs_link_if
  import ccs_pkg::*;
  ();
  logic                           common_enable;
  logic [CCS_COMPONENTS-1:0]      comp_enable;
  logic [CCS_COMPONENTS-1:0]      comp_status;
  logic [CCS_AW_W-1:0]            common_aw_en;
  logic [CCS_COMPONENTS-1:0]      comp_active;
  logic [CCS_COMPONENTS*CCS_AW_W-1:0] comp_aw_en;
  logic                           common_status;
  logic                           id_load;
  logic [7:0]                     id_value;
  logic [7:0]                     rep_id;
  modport hub   (output common_enable, comp_enable, comp_status,
                 common_aw_en, id_load, id_value,
                 input  comp_active, comp_aw_en, common_status, rep_id);
  modport gate  (input  common_enable, comp_enable, comp_status,
                 common_aw_en,
                 output comp_active, comp_aw_en, common_status);
  modport idrep (input  id_load, id_value, output rep_id);
endinterface : ccs_link_if

// *** core/ccs_pkg.sv ***
// shared constants for the common capability and status register block
package ccs_pkg;
  // register map
  localparam logic [11:0] CCS_OFF_CAP_STAT_ONE = 12'h004;
  localparam int          CCS_ADDR_W           = 12;
  localparam int          CCS_DATA_W           = 32;
  // field positions in common_capability_status_one
  localparam int CCS_MP_LSB   = 0;
  localparam int CCS_MP_MSB   = 2;
  localparam int CCS_RSV_LSB  = 3;
  localparam int CCS_RSV_MSB  = 21;
  localparam int CCS_VER_LSB  = 22;
  localparam int CCS_VER_MSB  = 23;
  localparam int CCS_RID_LSB  = 24;
  localparam int CCS_RID_MSB  = 31;
  // field values and reset values
  localparam logic [2:0] CCS_MP_SINGLE   = 3'h2;
  localparam logic [2:0] CCS_MP_FULL     = 3'h7;
  localparam logic [1:0] CCS_VER_ONE     = 2'h0;
  localparam logic [7:0] CCS_RID_RESET   = 8'h00;
  localparam logic [7:0] CCS_RID_NONE    = 8'h00;
  localparam logic [31:0] CCS_RDATA_NONE = 32'h0000_0000;
  // sizes of the component side
  localparam int CCS_COMPONENTS = 4;
  localparam int CCS_AW_W       = 3;
  // timing counts in clk_sys_i cycles
  localparam int CCS_READ_LAT   = 1;
  localparam int CCS_COPY_LAT   = 1;
  localparam int CCS_GATE_LAT   = 1;
endpackage : ccs_pkg

// *** core/ccs_regs.sv ***
// common capability and status register for one port of the device
`timescale 1ns/1ns
module ccs_regs
  import ccs_pkg::*;
#(
  parameter int PORT_COUNT   = 1,
  parameter bit PRIMARY_PORT = 1'b1,
  parameter bit MESH_CAPABLE = 1'b0
)(
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_i,
  input  wire logic                           flr_i,
  input  wire logic                           cfg_rd_i,
  input  wire logic                           cfg_wr_i,
  input  wire logic [CCS_ADDR_W-1:0]          cfg_addr_i,
  input  wire logic [CCS_DATA_W-1:0]          cfg_wdata_i,
  output logic      [CCS_DATA_W-1:0]          cfg_rdata_o,
  output logic                                cfg_rvalid_o,
  output logic                                cfg_wack_o,
  input  wire logic                           ctrl_id_wr_i,
  input  wire logic [7:0]                     ctrl_id_i,
  input  wire logic                           peer_id_wr_i,
  input  wire logic [7:0]                     peer_id_i,
  output logic                                id_copy_o,
  output logic      [7:0]                     id_copy_value_o,
  input  wire logic                           common_enable_i,
  input  wire logic [CCS_COMPONENTS-1:0]      comp_enable_i,
  input  wire logic [CCS_COMPONENTS-1:0]      comp_status_i,
  input  wire logic [CCS_AW_W-1:0]            common_aw_en_i,
  output logic      [CCS_COMPONENTS-1:0]      comp_active_o,
  output logic [CCS_COMPONENTS*CCS_AW_W-1:0]  comp_aw_en_o,
  output logic                                common_status_o,
  output logic      [2:0]                     port_multiplicity_o,
  output logic                                primary_ext_present_o,
  output logic                                rid_map_present_o,
  output logic      [7:0]                     replicated_id_o
);

  // capability bits are fixed by the build of this port
  localparam logic MULTI = (PORT_COUNT > 1);
  // a single-port device is always its own primary, never a mesh node
  localparam logic [2:0] MP_VALUE = MULTI ?
    {MESH_CAPABLE, PRIMARY_PORT, 1'b1} : CCS_MP_SINGLE;

  ccs_link_if lk ();

  // decode of the single mapped offset, used on read only; writes are not decoded
  function automatic logic hit_cap(input logic [CCS_ADDR_W-1:0] a);
    hit_cap = (a == CCS_OFF_CAP_STAT_ONE);
  endfunction : hit_cap

  // ------------------------------------------------------------------
  // identifier replication
  // ------------------------------------------------------------------

  logic       next_copy;
  logic [7:0] next_copy_value;
  logic       copy;
  logic [7:0] copy_value;
  logic       load;
  logic [7:0] load_value;

  // own control write wins over a peer copy in the same cycle
  always_comb begin
    load       = 1'b0;
    load_value = ctrl_id_i;
    if (ctrl_id_wr_i) begin
      load       = 1'b1;
      load_value = ctrl_id_i;
    end else if (peer_id_wr_i && MULTI) begin
      load       = 1'b1;
      load_value = peer_id_i;
    end
  end

  // forward our own assignment to the other ports of a multi-port device
  always_comb begin
    next_copy       = ctrl_id_wr_i & MULTI;
    next_copy_value = ctrl_id_wr_i ? ctrl_id_i : copy_value;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      copy       <= 1'b0;
      copy_value <= CCS_RID_RESET;
    end else begin
      copy       <= next_copy;
      copy_value <= next_copy_value;
    end
  end

  assign lk.id_load  = load;
  assign lk.id_value = load_value;

  ccs_id_replica u_id (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .flr_i     (flr_i),
    .lk        (lk)
  );

  // ------------------------------------------------------------------
  // component control and status
  // ------------------------------------------------------------------

  assign lk.common_enable = common_enable_i;
  assign lk.comp_enable   = comp_enable_i;
  assign lk.comp_status   = comp_status_i;
  assign lk.common_aw_en  = common_aw_en_i;

  ccs_comp_gate u_gate (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .lk        (lk)
  );

  // ------------------------------------------------------------------
  // register image
  // ------------------------------------------------------------------

  logic [CCS_DATA_W-1:0] cap_word;

  // reserved bits are forced low; nothing in here is writable
  always_comb begin
    cap_word = '0;
    cap_word[CCS_MP_MSB:CCS_MP_LSB]   = MP_VALUE;
    cap_word[CCS_VER_MSB:CCS_VER_LSB] = CCS_VER_ONE;
    cap_word[CCS_RID_MSB:CCS_RID_LSB] = lk.rep_id;
  end

  // ------------------------------------------------------------------
  // configuration access port
  // ------------------------------------------------------------------

  logic [CCS_DATA_W-1:0] next_rdata;
  logic                  next_rvalid;
  logic                  next_wack;
  logic [CCS_DATA_W-1:0] rdata;
  logic                  rvalid;
  logic                  wack;

  // unmapped reads answer zero; writes are acknowledged and dropped
  always_comb begin
    next_rdata  = CCS_RDATA_NONE;
    next_rvalid = cfg_rd_i;
    next_wack   = cfg_wr_i;
    if (cfg_rd_i && hit_cap(cfg_addr_i)) begin
      next_rdata = cap_word;
    end else if (cfg_rd_i) begin
      next_rdata = CCS_RDATA_NONE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata  <= CCS_RDATA_NONE;
      rvalid <= 1'b0;
      wack   <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
      wack   <= next_wack;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------

  // presence flags tell the neighbouring structures what to expose
  assign primary_ext_present_o = MP_VALUE[1];
  assign rid_map_present_o     = (MP_VALUE == CCS_MP_FULL);
  assign port_multiplicity_o   = MP_VALUE;
  assign replicated_id_o       = lk.rep_id;
  assign cfg_rdata_o           = rdata;
  assign cfg_rvalid_o          = rvalid;
  assign cfg_wack_o            = wack;
  assign id_copy_o             = copy;
  assign id_copy_value_o       = copy_value;
  assign comp_active_o         = lk.comp_active;
  assign comp_aw_en_o          = lk.comp_aw_en;
  assign common_status_o       = lk.common_status;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------

  rsvd_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cfg_rvalid_o |-> cfg_rdata_o[CCS_RSV_MSB:CCS_RSV_LSB] == '0)
    else $error("reserved bits read non-zero");

  version_val_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cfg_rvalid_o |-> cfg_rdata_o[CCS_VER_MSB:CCS_VER_LSB] == 2'h0)
    else $error("structure version is not version one");

  read_answer_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cfg_rd_i && hit_cap(cfg_addr_i) |=>
      cfg_rvalid_o && cfg_rdata_o == $past(cap_word))
    else $error("read of the register returned a wrong word");

  write_ignored_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cfg_wr_i && !load |=> $stable(cap_word))
    else $error("write altered the read-only register");

  single_port_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !MULTI |-> port_multiplicity_o == 3'h2)
    else $error("single-port device reports wrong multiplicity");

  multi_bit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    port_multiplicity_o[0] == (PORT_COUNT > 1))
    else $error("multi-port bit does not follow the port count");

  primary_pat_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    MULTI && PRIMARY_PORT |-> port_multiplicity_o[1:0] == 2'h3)
    else $error("primary port of multi-port device lacks x11b");

  primary_bit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    port_multiplicity_o[1] == (PRIMARY_PORT || !MULTI))
    else $error("primary bit does not match port role");

  mesh_bit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    port_multiplicity_o[2] == (MESH_CAPABLE && MULTI))
    else $error("mesh bit does not match capability");

  ext_present_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    primary_ext_present_o == port_multiplicity_o[1])
    else $error("extended structure flag disagrees with bit 1");

  rid_map_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rid_map_present_o == (port_multiplicity_o == 3'h7))
    else $error("routing map flag disagrees with field value");

  copy_out_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ctrl_id_wr_i && MULTI |=> id_copy_o &&
      id_copy_value_o == $past(ctrl_id_i))
    else $error("identifier not forwarded to the other ports");

  // a read in the cycle after a non-zero assignment must see it already
  rid_assigned_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ctrl_id_wr_i && ctrl_id_i != CCS_RID_NONE ##1
      cfg_rd_i && hit_cap(cfg_addr_i) |=>
      cfg_rdata_o[CCS_RID_MSB:CCS_RID_LSB] != CCS_RID_NONE)
    else $error("assigned identifier reads as unassigned");

  aw_bcast_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ##1 comp_aw_en_o[CCS_AW_W-1:0] == $past(common_aw_en_i))
    else $error("address width enable not applied to components");

  cap_read_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    cfg_rd_i && hit_cap(cfg_addr_i) ##1 cfg_rvalid_o);
  id_then_read_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    ctrl_id_wr_i ##2 cfg_rd_i && hit_cap(cfg_addr_i));
  flr_keep_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    replicated_id_o != 8'h00 && flr_i);
  common_off_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    !common_enable_i && comp_enable_i != '0);

endmodule : ccs_regs

// *** verif/ccs_regs_test.sv ***
// self-checking bench for the common capability and status register block
`timescale 1ns/1ns
module ccs_regs_test;
  import ccs_pkg::*;

  logic                              clk_sys_i       = 1'b0;
  logic                              rst_i           = 1'b1;
  logic                              flr_i           = 1'b0;
  logic                              cfg_rd_i        = 1'b0;
  logic                              cfg_wr_i        = 1'b0;
  logic [CCS_ADDR_W-1:0]             cfg_addr_i      = 12'h000;
  logic [CCS_DATA_W-1:0]             cfg_wdata_i     = 32'h0000_0000;
  logic                              ctrl_id_wr_i    = 1'b0;
  logic [7:0]                        ctrl_id_i       = 8'h00;
  logic                              peer_id_wr_i    = 1'b0;
  logic [7:0]                        peer_id_i       = 8'h00;
  logic                              common_enable_i = 1'b0;
  logic [CCS_COMPONENTS-1:0]         comp_enable_i   = 4'h0;
  logic [CCS_COMPONENTS-1:0]         comp_status_i   = 4'h0;
  logic [CCS_AW_W-1:0]               common_aw_en_i  = 3'h0;
  // index 0 single-port, 1 mesh two-port primary, 2 two-port secondary
  logic [2:0][CCS_DATA_W-1:0]        rdata;
  logic [2:0]                        rvalid;
  logic [2:0]                        wack;
  logic [2:0]                        idc;
  logic [2:0][7:0]                   idv;
  logic [2:0][CCS_COMPONENTS-1:0]    act;
  logic [2:0][CCS_COMPONENTS*CCS_AW_W-1:0] aw;
  logic [2:0]                        cst;
  logic [2:0][2:0]                   mp;
  logic [2:0]                        pex;
  logic [2:0]                        rmap;
  logic [2:0][7:0]                   rid;
  logic [2:0][7:0]                   rid_exp;
  logic [7:0]                        idv_exp;
  int                                n_mismatch = 0;
  int                                n_compared = 0;
  int                                seed       = 32'hcc9a3136;

  // 250 MHz system clock
  always #2 clk_sys_i = ~clk_sys_i;

  // all three builds see the same stimulus, so one sequence checks all three
  for (genvar g = 0; g < 3; g++) begin : g_port
    ccs_regs #(.PORT_COUNT((g == 0) ? 1 : 2), .PRIMARY_PORT(g != 2),
               .MESH_CAPABLE(g == 1)) i_ccs_regs (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .flr_i(flr_i),
      .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
      .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(rdata[g]),
      .cfg_rvalid_o(rvalid[g]), .cfg_wack_o(wack[g]),
      .ctrl_id_wr_i(ctrl_id_wr_i), .ctrl_id_i(ctrl_id_i),
      .peer_id_wr_i(peer_id_wr_i), .peer_id_i(peer_id_i),
      .id_copy_o(idc[g]), .id_copy_value_o(idv[g]),
      .common_enable_i(common_enable_i), .comp_enable_i(comp_enable_i),
      .comp_status_i(comp_status_i), .common_aw_en_i(common_aw_en_i),
      .comp_active_o(act[g]), .comp_aw_en_o(aw[g]),
      .common_status_o(cst[g]), .port_multiplicity_o(mp[g]),
      .primary_ext_present_o(pex[g]), .rid_map_present_o(rmap[g]),
      .replicated_id_o(rid[g]));
  end

  // multi-port field: single port 010b, mesh primary 111b, secondary 001b
  function automatic logic [2:0] exp_mp(input int i);
    return (i == 0) ? 3'h2 : (i == 1) ? 3'h7 : 3'h1;
  endfunction : exp_mp

  function automatic logic [31:0] exp_word(input int i, input logic [7:0] id);
    return {id, 2'h0, 19'h0_0000, exp_mp(i)};
  endfunction : exp_word

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc();
    @(negedge clk_sys_i);
  endtask : cyc

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // one read strobe; answer one cycle later, pulse gone the cycle after
  task automatic read_word(input logic [11:0] a);
    cfg_addr_i = a;
    cfg_rd_i   = 1'b1;
    cyc();
    cfg_rd_i   = 1'b0;
    for (int i = 0; i < 3; i++) begin
      chk("read valid", 32'h1, {31'h0, rvalid[i]});
      chk("read data", (a == 12'h004) ? exp_word(i, rid_exp[i]) : 32'h0,
          rdata[i]);
    end
    cyc();
    for (int i = 0; i < 3; i++) begin
      chk("read valid end", 32'h0, {31'h0, rvalid[i]});
    end
  endtask : read_word

  // identifier load from software and or from a peer port
  task automatic load_id(input logic own, input logic peer,
                         input logic [7:0] v, input logic [7:0] p);
    ctrl_id_wr_i = own;
    ctrl_id_i    = v;
    peer_id_wr_i = peer;
    peer_id_i    = p;
    if (own) begin
      rid_exp = {v, v, v};
      idv_exp = v;
    end else if (peer) begin
      rid_exp[1] = p;
      rid_exp[2] = p;
    end
    cyc();
    ctrl_id_wr_i = 1'b0;
    peer_id_wr_i = 1'b0;
    for (int i = 0; i < 3; i++) begin
      chk("replicated id", {24'h0, rid_exp[i]}, {24'h0, rid[i]});
      chk("id copy pulse", {31'h0, own && i != 0}, {31'h0, idc[i]});
    end
    chk("id copy value", {24'h0, idv_exp}, {24'h0, idv[1]});
    chk("id copy value", {24'h0, idv_exp}, {24'h0, idv[2]});
    read_word(12'h004);
  endtask : load_id

  // watchdog: a hang counts as a mismatch
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    logic [7:0] v;
    logic [3:0] en;
    rid_exp = 24'h00_0000;
    idv_exp = 8'h00;
    repeat (16) cyc();
    rst_i = 1'b0;
    cyc();
    for (int i = 0; i < 3; i++) begin
      chk("reset rid", 32'h0, {24'h0, rid[i]});
      chk("reset active", 32'h0, {28'h0, act[i]});
      chk("field", {29'h0, exp_mp(i)}, {29'h0, mp[i]});
      chk("primary ext", {31'h0, i != 2}, {31'h0, pex[i]});
      chk("rid map", {31'h0, i == 1}, {31'h0, rmap[i]});
    end
    read_word(12'h004);
    // write with random data is acknowledged and dropped
    cfg_addr_i  = 12'h004;
    cfg_wdata_i = $random(seed);
    cfg_wr_i    = 1'b1;
    cyc();
    cfg_wr_i    = 1'b0;
    chk("write ack", 32'h1, {31'h0, wack[0]});
    chk("write ack", 32'h1, {31'h0, wack[1]});
    chk("write ack", 32'h1, {31'h0, wack[2]});
    read_word(12'h004);
    read_word(12'h008);
    // random unmapped offset kept within the 12-bit space, above the word
    read_word(12'({$random(seed)} % 32'hff8) + 12'h008);
    // identifier copies, corner values among random ones
    load_id(1'b1, 1'b0, 8'hff, 8'h00);
    load_id(1'b1, 1'b0, 8'h01, 8'h00);
    for (int k = 0; k < 6; k++) begin
      v = $random(seed);
      load_id(1'b1, 1'b0, v | 8'h01, 8'h00);
    end
    v = $random(seed);
    load_id(1'b0, 1'b1, 8'h00, v | 8'h80);
    load_id(1'b1, 1'b1, 8'h3c, 8'hc3);
    // function level reset keeps the copy
    flr_i = 1'b1;
    repeat (2) cyc();
    flr_i = 1'b0;
    cyc();
    read_word(12'h004);
    // conventional reset clears the copy
    rst_i = 1'b1;
    repeat (2) cyc();
    rst_i   = 1'b0;
    rid_exp = 24'h00_0000;
    cyc();
    read_word(12'h004);
    // component gating, aggregation and broadcast
    for (int k = 0; k < 24; k++) begin
      en              = (k == 0) ? 4'hf : 4'($random(seed));
      comp_enable_i   = en;
      common_enable_i = (k == 0) ? 1'b0 : 1'($random(seed));
      comp_status_i   = (k == 1) ? 4'h0 : 4'($random(seed));
      common_aw_en_i  = 3'($random(seed));
      cyc();
      for (int i = 0; i < 3; i++) begin
        chk("active", {28'h0, en & {4{common_enable_i}}},
            {28'h0, act[i]});
        chk("status", {31'h0, |comp_status_i}, {31'h0, cst[i]});
        chk("aw", {20'h0, {4{common_aw_en_i}}}, {20'h0, aw[i]});
      end
    end
    report_and_stop();
  end
endmodule : ccs_regs_test
